// ===== hdl/eas_pkg.sv
package eas_pkg;
   localparam int unsigned DATA_W = 16;
   localparam int unsigned ADDR_W = 12;
   // Register map
   localparam logic [11:0] STATUS_ADDR = 12'h0f0;
   localparam logic [11:0] IRQ_STATUS_ADDR = 12'h0f8;
   localparam logic [11:0] IRQ_ENABLE_ADDR = 12'h0fa;
   localparam logic [11:0] IRQ_CLEAR_ADDR = 12'h0fc;
   // Field positions
   localparam int unsigned BIT_RSVD15 = 15;
   localparam int unsigned BIT_HW_EEE = 14;
   localparam int unsigned BIT_TX_LPI_SEEN = 13;
   localparam int unsigned BIT_TX_LPI_NOW = 12;
   localparam int unsigned BIT_RX_LPI_SEEN = 11;
   localparam int unsigned BIT_RX_LPI_NOW = 10;
   localparam int unsigned BIT_RSVD9 = 9;
   localparam int unsigned BIT_RSVD8 = 8;
   localparam int unsigned BIT_NP_LOC_ABLE = 6;
   localparam int unsigned BIT_NP_LOC = 5;
   localparam int unsigned BIT_PD_FAULT = 4;
   localparam int unsigned BIT_LP_NP_ABLE = 3;
   localparam int unsigned BIT_NP_ABLE = 2;
   localparam int unsigned BIT_PAGE_RX = 1;
   localparam int unsigned BIT_LP_AN_ABLE = 0;
   // Reset values
   localparam logic RSVD15_RST = 1'b1;
   localparam logic [1:0] RSVD98_RST = 2'h0;
   localparam logic NP_LOC_ABLE_VAL = 1'b1;
   localparam logic NP_LOC_VAL = 1'b1;
   localparam logic NP_ABLE_VAL = 1'b1;
   // Interrupt layout: one bit per sticky event
   localparam int unsigned IRQ_W = 4;
   localparam int unsigned IRQ_TX_LPI = 0;
   localparam int unsigned IRQ_RX_LPI = 1;
   localparam int unsigned IRQ_PD_FAULT = 2;
   localparam int unsigned IRQ_PAGE_RX = 3;
endpackage

// ===== hdl/eas_status_reg.sv
// Design decision made here: the address-and-strobe port.
`timescale 1ns/1ps
module eas_status_reg
(
   input wire logic clk,
   input wire logic reset,
   input wire logic [eas_pkg::ADDR_W-1:0] addr,
   input wire logic [eas_pkg::DATA_W-1:0] wdata,
   input wire logic wr,
   input wire logic rd,
   output logic [eas_pkg::DATA_W-1:0] rdata,
   output logic irq,
   input wire logic hw_eee_enabled,
   input wire logic tx_lpi,
   input wire logic rx_lpi,
   input wire logic pd_fault,
   input wire logic page_received,
   input wire logic lp_next_page_able,
   input wire logic lp_autoneg_able
);
   // Pin inputs pass two flops before use
   logic [6:0] sync1_reg;
   logic [6:0] sync2_reg;
   logic tx_seen_reg;
   logic rx_seen_reg;
   logic pd_fault_reg;
   logic page_rx_reg;
   logic rsvd15_reg;
   logic [1:0] rsvd98_reg;
   logic [eas_pkg::IRQ_W-1:0] irq_stat_reg;
   logic [eas_pkg::IRQ_W-1:0] irq_en_reg;
   logic [eas_pkg::DATA_W-1:0] rdata_reg;
   logic irq_reg;

   wire logic s_hw_eee = sync2_reg[0];
   wire logic s_tx_lpi = sync2_reg[1];
   wire logic s_rx_lpi = sync2_reg[2];
   wire logic s_pd_fault = sync2_reg[3];
   wire logic s_page_rx = sync2_reg[4];
   wire logic s_lp_np = sync2_reg[5];
   wire logic s_lp_an = sync2_reg[6];

   wire logic sel_status = addr == eas_pkg::STATUS_ADDR;
   wire logic sel_irq_stat = addr == eas_pkg::IRQ_STATUS_ADDR;
   wire logic sel_irq_en = addr == eas_pkg::IRQ_ENABLE_ADDR;
   wire logic sel_irq_clr = addr == eas_pkg::IRQ_CLEAR_ADDR;
   wire logic wr_status = wr && sel_status;
   wire logic rd_status = rd && sel_status;
   wire logic wr_irq_clr = wr && sel_irq_clr;

   // Set wins over a clear in the same cycle, so an event is never lost to a racing clear
   function automatic logic sticky_next(input logic set, input logic held, input logic clr);
      sticky_next = set | (held & ~clr);
   endfunction

   wire logic tx_clr = wr_status & wdata[eas_pkg::BIT_TX_LPI_SEEN];
   wire logic rx_clr = wr_status & wdata[eas_pkg::BIT_RX_LPI_SEEN];
   wire logic tx_seen_next = sticky_next(s_tx_lpi, tx_seen_reg, tx_clr);
   wire logic rx_seen_next = sticky_next(s_rx_lpi, rx_seen_reg, rx_clr);
   wire logic pd_fault_next = sticky_next(s_pd_fault, pd_fault_reg, rd_status);
   wire logic page_rx_next = sticky_next(s_page_rx, page_rx_reg, rd_status);

   wire logic [eas_pkg::IRQ_W-1:0] irq_ev;
   assign irq_ev[eas_pkg::IRQ_TX_LPI] = s_tx_lpi;
   assign irq_ev[eas_pkg::IRQ_RX_LPI] = s_rx_lpi;
   assign irq_ev[eas_pkg::IRQ_PD_FAULT] = s_pd_fault;
   assign irq_ev[eas_pkg::IRQ_PAGE_RX] = s_page_rx;
   wire logic [eas_pkg::IRQ_W-1:0] irq_clr = wr_irq_clr ? wdata[eas_pkg::IRQ_W-1:0] :
      {eas_pkg::IRQ_W{1'b0}};
   wire logic [eas_pkg::IRQ_W-1:0] irq_stat_next = irq_ev | (irq_stat_reg & ~irq_clr);

   logic [eas_pkg::DATA_W-1:0] status_word;
   always_comb
   begin
      status_word = '0; // Bit 7 and unlisted bits read zero
      status_word[eas_pkg::BIT_RSVD15] = rsvd15_reg;
      status_word[eas_pkg::BIT_HW_EEE] = s_hw_eee;
      status_word[eas_pkg::BIT_TX_LPI_SEEN] = tx_seen_reg;
      status_word[eas_pkg::BIT_TX_LPI_NOW] = s_tx_lpi;
      status_word[eas_pkg::BIT_RX_LPI_SEEN] = rx_seen_reg;
      status_word[eas_pkg::BIT_RX_LPI_NOW] = s_rx_lpi;
      status_word[eas_pkg::BIT_RSVD9] = rsvd98_reg[1];
      status_word[eas_pkg::BIT_RSVD8] = rsvd98_reg[0];
      status_word[eas_pkg::BIT_NP_LOC_ABLE] = eas_pkg::NP_LOC_ABLE_VAL;
      status_word[eas_pkg::BIT_NP_LOC] = eas_pkg::NP_LOC_VAL;
      status_word[eas_pkg::BIT_PD_FAULT] = pd_fault_reg;
      status_word[eas_pkg::BIT_LP_NP_ABLE] = s_lp_np;
      status_word[eas_pkg::BIT_NP_ABLE] = eas_pkg::NP_ABLE_VAL;
      status_word[eas_pkg::BIT_PAGE_RX] = page_rx_reg;
      status_word[eas_pkg::BIT_LP_AN_ABLE] = s_lp_an;
   end

   // Clear register reads zero; unmapped addresses read zero
   wire logic [eas_pkg::DATA_W-1:0] rdata_next =
      !rd ? {eas_pkg::DATA_W{1'b0}} :
      sel_status ? status_word :
      sel_irq_stat ? {{(eas_pkg::DATA_W-eas_pkg::IRQ_W){1'b0}}, irq_stat_reg} :
      sel_irq_en ? {{(eas_pkg::DATA_W-eas_pkg::IRQ_W){1'b0}}, irq_en_reg} :
      {eas_pkg::DATA_W{1'b0}};

   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         sync1_reg <= 7'h00;
         sync2_reg <= 7'h00;
      end
      else
      begin
         sync1_reg <= {lp_autoneg_able, lp_next_page_able, page_received, pd_fault, rx_lpi,
            tx_lpi, hw_eee_enabled};
         sync2_reg <= sync1_reg;
      end
   end

   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         tx_seen_reg <= 1'b0;
         rx_seen_reg <= 1'b0;
         pd_fault_reg <= 1'b0;
         page_rx_reg <= 1'b0;
         rsvd15_reg <= eas_pkg::RSVD15_RST;
         rsvd98_reg <= eas_pkg::RSVD98_RST;
      end
      else
      begin
         tx_seen_reg <= tx_seen_next;
         rx_seen_reg <= rx_seen_next;
         pd_fault_reg <= pd_fault_next;
         page_rx_reg <= page_rx_next;
         if (wr_status)
         begin
            rsvd15_reg <= wdata[eas_pkg::BIT_RSVD15];
            rsvd98_reg <= wdata[eas_pkg::BIT_RSVD9:eas_pkg::BIT_RSVD8];
         end
      end
   end

   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         irq_stat_reg <= '0;
         irq_en_reg <= '0;
         rdata_reg <= '0;
         irq_reg <= 1'b0;
      end
      else
      begin
         irq_stat_reg <= irq_stat_next;
         if (wr && sel_irq_en)
            irq_en_reg <= wdata[eas_pkg::IRQ_W-1:0];
         rdata_reg <= rdata_next;
         irq_reg <= |(irq_stat_next & irq_en_reg);
      end
   end

   assign rdata = rdata_reg;
   assign irq = irq_reg;
endmodule

// ===== verification/eas_status_reg_checker.sv
`timescale 1ns/1ps
module eas_status_reg_checker
(
   input logic clk,
   input logic reset,
   input logic [11:0] addr,
   input logic [15:0] wdata,
   input logic wr,
   input logic rd,
   input logic [15:0] rdata,
   input logic irq,
   input logic hw_eee_enabled,
   input logic tx_lpi,
   input logic rx_lpi,
   input logic pd_fault,
   input logic page_received,
   input logic lp_next_page_able,
   input logic lp_autoneg_able
);
   wire st = rd && addr == eas_pkg::STATUS_ADDR;
   wire [4:0] lv = {hw_eee_enabled, tx_lpi, rx_lpi, lp_next_page_able, lp_autoneg_able};
   wire [4:0] lb = {rdata[14], rdata[12], rdata[10], rdata[3], rdata[0]};
   default clocking @(posedge clk); endclocking
   default disable iff (reset);
   idle_zero_a: assert property (!$past(rd) |-> rdata == 16'h0000)
      else $error("rdata not idle");
   fixed_bits_a: assert property (st |=> rdata[7:5] == 3'h3 && rdata[2])
      else $error("fixed bits");
   live_bits_a: assert property ($stable(lv)[*4] ##0 st |=> lb == $past(lv))
      else $error("live bits");
   tx_sticky_a: assert property (tx_lpi && !wr ##1 !wr[*3] ##1 st |=> rdata[13])
      else $error("tx flag lost");
   rx_sticky_a: assert property (rx_lpi && !wr ##1 !wr[*3] ##1 st |=> rdata[11])
      else $error("rx flag lost");
   wr_clear_a: assert property ((!tx_lpi)[*4] ##0 wr && addr == eas_pkg::STATUS_ADDR
      && wdata[13] ##2 st |=> !rdata[13]) else $error("tx flag kept");
   fault_latch_a: assert property (pd_fault && !rd ##1 !rd[*3] ##1 st |=> rdata[4])
      else $error("fault lost");
   rd_clear_a: assert property ((!(pd_fault || page_received))[*5] ##0 st ##2 st
      |=> !rdata[4] && !rdata[1]) else $error("read clear");
   cover property (st ##1 rdata[13]);
   cover property (st ##1 rdata[4]);
   cover property (irq);
endmodule

// ===== verification/eas_status_reg_tb_top.sv
`timescale 1ns/1ps
module eas_status_reg_tb_top;
   localparam logic [11:0] SA = eas_pkg::STATUS_ADDR;
   logic clk, reset, wr, rd, irq;
   logic [11:0] addr;
   logic [15:0] wdata, rdata;
   logic [6:0] ev;
   int errors, n_compared;
   eas_status_reg uut (.clk, .reset, .addr, .wdata, .wr, .rd, .rdata, .irq,
      .hw_eee_enabled(ev[6]), .tx_lpi(ev[5]), .rx_lpi(ev[4]), .pd_fault(ev[3]),
      .page_received(ev[2]), .lp_next_page_able(ev[1]), .lp_autoneg_able(ev[0]));
   always #5 clk = ~clk;
   task automatic chk(input logic [15:0] g, input logic [15:0] e);
      n_compared++;
      if (g !== e)
      begin
         errors++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask
   task automatic wr_t(input logic [11:0] a, input logic [15:0] d);
      @(posedge clk);
      wr <= 1'b1;
      addr <= a;
      wdata <= d;
      @(posedge clk);
      wr <= 1'b0;
   endtask
   task automatic rd_t(input logic [11:0] a, input logic [15:0] e);
      @(posedge clk);
      rd <= 1'b1;
      addr <= a;
      @(posedge clk);
      rd <= 1'b0;
      #1;
      chk(rdata, e);
   endtask
   // Waits past the two sync stages, the latch and the irq register
   task automatic ev_t(input logic [6:0] v);
      @(posedge clk);
      ev <= v;
      repeat (5) @(posedge clk);
      #1;
   endtask
   task automatic finish_test;
      $display("compared %0d errors %0d", n_compared, errors);
      if (errors == 0 && n_compared > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   task automatic test_defaults;
      rd_t(SA, 16'h8064);
      rd_t(12'h0f2, 16'h0000);
      wr_t(SA, 16'h03ff);
      rd_t(SA, 16'h0364);
      wr_t(SA, 16'h8000);
      $display("defaults done");
   endtask
   task automatic test_live;
      ev_t(7'h43);
      rd_t(SA, 16'hc06d);
      ev_t(7'h00);
      rd_t(SA, 16'h8064);
      $display("live done");
   endtask
   task automatic test_lpi_flags;
      wr_t(eas_pkg::IRQ_ENABLE_ADDR, 16'h0001);
      ev_t(7'h10);
      chk({15'h0, irq}, 16'h0000);
      rd_t(eas_pkg::IRQ_STATUS_ADDR, 16'h0002);
      ev_t(7'h30);
      chk({15'h0, irq}, 16'h0001);
      rd_t(SA, 16'hbc64);
      ev_t(7'h00);
      rd_t(SA, 16'ha864);
      wr_t(SA, 16'h8000);
      rd_t(SA, 16'ha864);
      wr_t(SA, 16'ha000);
      rd_t(SA, 16'h8864);
      wr_t(eas_pkg::IRQ_CLEAR_ADDR, 16'h000f);
      wr_t(SA, 16'h8800);
      rd_t(SA, 16'h8064);
      chk({15'h0, irq}, 16'h0000);
      $display("idle flags done");
   endtask
   task automatic test_read_clear;
      ev_t(7'h0c);
      ev_t(7'h00);
      rd_t(SA, 16'h8076);
      rd_t(SA, 16'h8064);
      $display("read clear done");
   endtask
   // Inputs are idle across the pulse so no live-bit check straddles it
   task automatic test_mid_reset;
      wr_t(eas_pkg::IRQ_ENABLE_ADDR, 16'h0001);
      ev_t(7'h30);
      ev_t(7'h00);
      chk({15'h0, irq}, 16'h0001);
      @(posedge clk);
      reset <= 1'b1;
      repeat (2) @(posedge clk);
      #1;
      chk({15'h0, irq}, 16'h0000);
      chk(rdata, 16'h0000);
      @(posedge clk);
      reset <= 1'b0;
      rd_t(SA, 16'h8064);
      rd_t(eas_pkg::IRQ_ENABLE_ADDR, 16'h0000);
      $display("mid reset done");
   endtask
   initial
   begin
      clk = 1'b0;
      reset = 1'b1;
      {wr, rd, addr, wdata, ev} = '0;
      repeat (10) @(posedge clk);
      reset <= 1'b0;
      test_defaults();
      test_live();
      test_lpi_flags();
      test_read_clear();
      test_mid_reset();
      finish_test();
   end
   initial
   begin
      #20000;
      errors++;
      finish_test();
   end
endmodule
bind eas_status_reg eas_status_reg_checker chk_i (.*);
